// File: common/dsc_pkg.sv
// shared constants for the device state and sequencing control block
package dsc_pkg;
   // register offsets on the serial control port
   localparam logic [7:0] ADDR_CTRL = 8'h24;
   localparam logic [7:0] ADDR_CTRL2 = 8'h25;
   // first control register fields
   localparam int B_SEQ_OFF = 7;
   localparam int B_RELOAD = 6;
   localparam int B_LOCK9 = 5;
   localparam int B_RST_PP = 3;
   localparam int B_HOLD = 2;
   localparam int B_SLP = 1;
   localparam int B_OFF = 0;
   // writable bits: lock is read-only, bit 4 reserved
   localparam logic [7:0] CTRL_WMASK = 8'hcf;
   localparam logic [7:0] CTRL_LOCK_MASK = 8'h20;
   // bits cleared on reaching OFF
   localparam logic [7:0] CTRL_OFF_CLR = 8'h07;
   // second control register fields
   localparam int B_SLP_EN = 7;
   localparam int B_IRQ_PP = 6;
   localparam int B_SLOT_HI = 5;
   localparam int B_SLOT_LO = 4;
   localparam int B_SLP_POL = 3;
   localparam int B_LP_OFF = 2;
   localparam int B_LP_RST = 1;
   localparam int B_IRQ_POL = 0;
   // programmed defaults, normally from one-time-programmable memory
   localparam logic [7:0] CTRL_OTP_DEF = 8'h40;
   localparam logic [7:0] CTRL2_OTP_DEF = 8'h70;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int SLOT0_US = 30;
   localparam int SLOT1_US = 200;
   localparam int SLOT2_US = 500;
   localparam int SLOT3_MS = 2;
   localparam int LP_WARN_S = 4;
   localparam int LP_OFF_S = 5;
   localparam int SLOT0_CYCLES = SLOT0_US * CLK_MHZ;
   localparam int SLOT1_CYCLES = SLOT1_US * CLK_MHZ;
   localparam int SLOT2_CYCLES = SLOT2_US * CLK_MHZ;
   localparam int SLOT3_CYCLES = SLOT3_MS * 1000 * CLK_MHZ;
   localparam int LP_WARN_CYCLES = LP_WARN_S * 1000000 * CLK_MHZ;
   localparam int LP_OFF_CYCLES = LP_OFF_S * 1000000 * CLK_MHZ;
   // device states, gray along off-up-active-sleep
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_UP = 3'h1,
      ST_ACT = 3'h3,
      ST_SLP = 3'h2,
      ST_DOWN = 3'h7
   } dev_state_t;
endpackage

// File: hdl/device_state_control.sv
// device state control: registers, power sequencer, long press, pads
//
// Behaviour
// - shutdown all at once, or one slot each in reverse start order
// - reload bit set restores register defaults on entering OFF
// - lock makes ninth regulator follow sequence only, control ignored
// - reset output pad is open-drain or push-pull by control bit
// - hold bit keeps device on without off requests; cleared in OFF
// - writing sleep-allow 0 wakes from SLEEP; bit cleared in OFF
// - writing sleep-allow 1 permits SLEEP when no off request pending
// - switch-off bit starts transition to OFF; cleared at OFF
// - reserved control bit reads zero, writes ignored
// - sleep pin ignored unless enabled; then acted on at chosen level
// - sleep polarity bit picks active high or active low pin
// - interrupt pad is open-drain or push-pull by control bit
// - slot field picks 30 us, 200 us, 500 us or 2 ms slots
// - button held low 4 s raises interrupt, 5 s enters OFF
// - long press with reset also reloads defaults; wins over plain
// - interrupt polarity 0 active low, 1 active high
// - button used as reset input ignores both long-press bits
// - both registers reset to programmed defaults on power-on reset
module device_state_control
   import dsc_pkg::*;
#(
   parameter int NUM_RES = 8,
   parameter int SLOT0_CYC = SLOT0_CYCLES,
   parameter int SLOT1_CYC = SLOT1_CYCLES,
   parameter int SLOT2_CYC = SLOT2_CYCLES,
   parameter int SLOT3_CYC = SLOT3_CYCLES,
   parameter int LP_WARN_CYC = LP_WARN_CYCLES,
   parameter int LP_OFF_CYC = LP_OFF_CYCLES,
   parameter logic [7:0] CTRL_DEF = CTRL_OTP_DEF,
   parameter logic [7:0] CTRL2_DEF = CTRL2_OTP_DEF
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WE,
   input wire logic REG_RE,
   output logic [7:0] REG_RDATA,
   input wire logic ON_REQUEST,
   input wire logic SLEEP_IN,
   input wire logic POWER_BUTTON_IN_N,
   input wire logic BUTTON_IS_RESET,
   input wire logic IRQ_REQ,
   input wire logic NINTH_REG_REQ,
   output logic [NUM_RES-1:0] RESOURCE_EN,
   output logic NINTH_REG_EN,
   output logic IRQ_PAD_O,
   output logic IRQ_PAD_OE,
   output logic POWER_ON_RESET_OUT_N_O,
   output logic POWER_ON_RESET_OUT_N_OE,
   output logic [2:0] DEVICE_STATE,
   output logic LONG_PRESS_WARN
);
   localparam int SLW = $clog2(SLOT3_CYC + 1);
   localparam int LPW = $clog2(LP_OFF_CYC + 1);
   localparam int IW = $clog2(NUM_RES);
   localparam logic [IW-1:0] LAST_RES = IW'(NUM_RES - 1);

   // refuse settings the counters cannot serve
   if (NUM_RES < 2 || SLOT0_CYC < 1 || SLOT0_CYC > SLOT1_CYC ||
       SLOT1_CYC > SLOT2_CYC || SLOT2_CYC > SLOT3_CYC ||
       LP_WARN_CYC < 1 || LP_WARN_CYC >= LP_OFF_CYC) begin : g_chk
      $error("device_state_control: bad parameter set");
   end

   // last count of a slot for a given length code
   function automatic logic [SLW-1:0] slot_last(input logic [1:0] sel);
      case (sel)
         2'h0: slot_last = SLW'(SLOT0_CYC - 1);
         2'h1: slot_last = SLW'(SLOT1_CYC - 1);
         2'h2: slot_last = SLW'(SLOT2_CYC - 1);
         default: slot_last = SLW'(SLOT3_CYC - 1);
      endcase
   endfunction

   // pad drive {out, enable}; open-drain only ever pulls low
   function automatic logic [1:0] pad_drive(input logic active,
                                            input logic act_high,
                                            input logic push_pull);
      logic level;
      level = active ~^ act_high;
      if (push_pull) begin
         pad_drive = {level, 1'b1};
      end else begin
         pad_drive = {1'b0, ~level};
      end
   endfunction

   logic [7:0] ctrl;
   logic [7:0] ctrl2;
   dev_state_t state;
   dev_state_t next_state;
   logic [SLW-1:0] slot_cnt;
   logic [IW-1:0] slot_idx;
   logic [LPW-1:0] lp_cnt;
   logic lp_warn;
   logic lp_off_flag;
   logic off_rst_flag;

   // field decode
   wire seq_sel = ctrl[B_SEQ_OFF];
   wire reload_sel = ctrl[B_RELOAD];
   wire lock9 = ctrl[B_LOCK9];
   wire hold = ctrl[B_HOLD];
   wire slp_allow = ctrl[B_SLP];
   wire sw_off = ctrl[B_OFF];
   wire slp_en = ctrl2[B_SLP_EN];
   wire slp_pol = ctrl2[B_SLP_POL];
   wire [1:0] slot_sel = ctrl2[B_SLOT_HI:B_SLOT_LO];

   // register strobes; reserved and lock bits cannot be written
   wire wr_ctrl = REG_WE && (REG_ADDR == ADDR_CTRL);
   wire wr_ctrl2 = REG_WE && (REG_ADDR == ADDR_CTRL2);
   wire [7:0] ctrl_wval = (REG_WDATA & CTRL_WMASK) |
                          (ctrl & CTRL_LOCK_MASK);
   wire [7:0] rd_val = (REG_ADDR == ADDR_CTRL) ? ctrl :
                       (REG_ADDR == ADDR_CTRL2) ? ctrl2 : 8'h00;

   // sleep pin qualified by enable and polarity
   wire sleep_pin = slp_en && (SLEEP_IN ^ slp_pol);
   wire sleep_go = slp_allow && (!slp_en || sleep_pin);

   // long press, not while the button serves as a reset input
   wire lp_allowed = (ctrl2[B_LP_OFF] || ctrl2[B_LP_RST]) &&
                     !BUTTON_IS_RESET;
   wire on_state = (state == ST_ACT) || (state == ST_SLP);
   wire pressing = lp_allowed && !POWER_BUTTON_IN_N && on_state;
   wire hit_warn = pressing && (lp_cnt == LPW'(LP_WARN_CYC - 1));
   wire hit_off = pressing && (lp_cnt == LPW'(LP_OFF_CYC - 1));

   // switch-off causes and staying-on terms
   wire off_any = sw_off || off_rst_flag || lp_off_flag;
   wire stay_on = ON_REQUEST || hold;
   wire in_seq = (state == ST_UP) || (state == ST_DOWN);
   wire slot_tick = in_seq && (slot_cnt == slot_last(slot_sel));
   wire last_slot = slot_idx == LAST_RES;
   wire enter_off = (next_state == ST_OFF) && (state != ST_OFF);
   wire reload = enter_off && (reload_sel || off_rst_flag);
   wire [1:0] irq_pad = pad_drive(IRQ_REQ || lp_warn, ctrl2[B_IRQ_POL],
                                  ctrl2[B_IRQ_PP]);
   wire [1:0] rst_pad = pad_drive(!on_state, 1'b0,
                                  ctrl[B_RST_PP]);

   // next device state
   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (ON_REQUEST) begin
               next_state = ST_UP;
            end
         end
         ST_UP: begin
            if (slot_tick && last_slot) begin
               next_state = ST_ACT;
            end
         end
         ST_ACT: begin
            if (off_any || !stay_on) begin
               next_state = ST_DOWN;
            end else if (sleep_go) begin
               next_state = ST_SLP;
            end
         end
         ST_SLP: begin
            if (off_any || !stay_on) begin
               next_state = ST_DOWN;
            end else if (!sleep_go) begin
               next_state = ST_ACT;
            end
         end
         ST_DOWN: begin
            if (!seq_sel || (slot_tick && last_slot)) begin
               next_state = ST_OFF;
            end
         end
         default: next_state = ST_OFF;
      endcase
   end

   // state register
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // slot timer, cleared outside sequencing and on state change
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         slot_cnt <= '0;
         slot_idx <= '0;
      end else if (!in_seq || next_state != state) begin
         slot_cnt <= '0;
         slot_idx <= '0;
      end else if (slot_tick) begin
         slot_cnt <= '0;
         slot_idx <= slot_idx + 1'b1;
      end else begin
         slot_cnt <= slot_cnt + 1'b1;
      end
   end

   // resources: one enabled per slot, released in reverse order or all at once
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         RESOURCE_EN <= '0;
      end else if (state == ST_UP && slot_tick) begin
         RESOURCE_EN[slot_idx] <= 1'b1;
      end else if (state == ST_DOWN && !seq_sel) begin
         RESOURCE_EN <= '0;
      end else if (state == ST_DOWN && slot_tick) begin
         RESOURCE_EN[LAST_RES - slot_idx] <= 1'b0;
      end
   end

   // long-press timer restarts whenever the press ends
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         lp_cnt <= '0;
      end else if (!pressing) begin
         lp_cnt <= '0;
      end else if (!hit_off && lp_cnt != LPW'(LP_OFF_CYC - 1)) begin
         lp_cnt <= lp_cnt + 1'b1;
      end
   end

   // long-press flags; set wins, reset variant has priority
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         lp_warn <= 1'b0;
         lp_off_flag <= 1'b0;
         off_rst_flag <= 1'b0;
      end else begin
         if (hit_warn) begin
            lp_warn <= 1'b1;
         end else if (POWER_BUTTON_IN_N || !on_state) begin
            lp_warn <= 1'b0;
         end
         if (hit_off && ctrl2[B_LP_RST]) begin
            off_rst_flag <= 1'b1;
         end else if (hit_off) begin
            lp_off_flag <= 1'b1;
         end else if (state == ST_OFF) begin
            off_rst_flag <= 1'b0;
            lp_off_flag <= 1'b0;
         end
      end
   end

   // control registers; a host write in the same cycle wins over clears
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl <= CTRL_DEF & ~8'h10;
         ctrl2 <= CTRL2_DEF;
      end else begin
         if (wr_ctrl) begin
            ctrl <= ctrl_wval;
         end else if (reload) begin
            ctrl <= CTRL_DEF & ~(CTRL_OFF_CLR | 8'h10);
         end else if (enter_off) begin
            ctrl <= ctrl & ~CTRL_OFF_CLR;
         end
         if (wr_ctrl2) begin
            ctrl2 <= REG_WDATA;
         end else if (reload) begin
            ctrl2 <= CTRL2_DEF;
         end
      end
   end

   // ninth regulator: sequence-owned when locked
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         NINTH_REG_EN <= 1'b0;
      end else if (state == ST_OFF) begin
         NINTH_REG_EN <= 1'b0;
      end else if (lock9) begin
         NINTH_REG_EN <= 1'b1;
      end else begin
         NINTH_REG_EN <= NINTH_REG_REQ;
      end
   end

   // registered outputs; irq pad starts released, reset pad driven low whenever the state is not ACTIVE or SLEEP
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
         IRQ_PAD_O <= 1'b0;
         IRQ_PAD_OE <= 1'b0;
         POWER_ON_RESET_OUT_N_O <= 1'b0;
         POWER_ON_RESET_OUT_N_OE <= 1'b1;
         DEVICE_STATE <= ST_OFF;
         LONG_PRESS_WARN <= 1'b0;
      end else begin
         if (REG_RE) begin
            REG_RDATA <= rd_val;
         end
         IRQ_PAD_O <= irq_pad[1];
         IRQ_PAD_OE <= irq_pad[0];
         POWER_ON_RESET_OUT_N_O <= rst_pad[1];
         POWER_ON_RESET_OUT_N_OE <= rst_pad[0];
         DEVICE_STATE <= state;
         LONG_PRESS_WARN <= lp_warn;
      end
   end

   // checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   sequence s_warn_hit;
      hit_warn;
   endsequence
   sequence s_warn_seen;
      ##2 LONG_PRESS_WARN;
   endsequence

   property p_simul_off;
      state == ST_DOWN && !seq_sel |=> state == ST_OFF
         ##1 RESOURCE_EN == '0;
   endproperty
   a_simul_off: assert property (p_simul_off)
      else $error("simultaneous shutdown failed");

   property p_seq_first;
      state == ST_DOWN && seq_sel && slot_tick && slot_idx == '0
         |=> !RESOURCE_EN[LAST_RES];
   endproperty
   a_seq_first: assert property (p_seq_first)
      else $error("last enabled not first released");

   property p_reload;
      reload && !wr_ctrl |=> ctrl[B_SEQ_OFF] == CTRL_DEF[B_SEQ_OFF];
   endproperty
   a_reload: assert property (p_reload)
      else $error("defaults not reloaded in off");

   property p_lock_ro;
      wr_ctrl |=> ctrl[B_LOCK9] == $past(ctrl[B_LOCK9]);
   endproperty
   a_lock_ro: assert property (p_lock_ro)
      else $error("lock bit changed by write");

   property p_nine_off;
      state == ST_OFF && $past(state) == ST_OFF |-> !NINTH_REG_EN;
   endproperty
   a_nine_off: assert property (p_nine_off)
      else $error("ninth regulator on in off");

   property p_off_clear;
      enter_off && !wr_ctrl |=> (ctrl & CTRL_OFF_CLR) == 8'h00;
   endproperty
   a_off_clear: assert property (p_off_clear)
      else $error("control bits not cleared in off");

   property p_hold;
      state == ST_ACT && hold && !off_any && !sleep_go |=> state == ST_ACT;
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold did not keep device on");

   property p_rsvd;
      REG_RE && REG_ADDR == ADDR_CTRL |=> !REG_RDATA[4];
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bit read nonzero");

   property p_sleep_ign;
      state == ST_ACT && !slp_en && slp_allow && stay_on && !off_any
         |=> state == ST_SLP;
   endproperty
   a_sleep_ign: assert property (p_sleep_ign)
      else $error("sleep pin not ignored");

   property p_lp_warn;
      s_warn_hit |-> s_warn_seen;
   endproperty
   a_lp_warn: assert property (p_lp_warn)
      else $error("long press warning missing");

   property p_irq_od;
      IRQ_PAD_OE && !$past(ctrl2[B_IRQ_PP]) |-> !IRQ_PAD_O;
   endproperty
   a_irq_od: assert property (p_irq_od)
      else $error("open-drain irq pad drove high");

endmodule // device_state_control

// File: tb/host_port_model.sv
// host model driving the register port of the state control block
module host_port_model (
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_we,
   output logic reg_re,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_we = 1'b0;
      reg_re = 1'b0;
   end

   // one write; an edge passes first so strobes never toggle twice
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_we = 1'b1;
      @(posedge clock);
      #1;
      reg_we = 1'b0;
      reg_addr = ~a; // released bus never shows the old address
      reg_wdata = ~d;
   endtask

   // one read; data is registered on the edge that takes the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_re = 1'b1;
      @(posedge clock);
      #1;
      reg_re = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule // host_port_model

// File: tb/tb.sv
// self-checking bench for the device state control block
module tb;
   import dsc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int slot_cyc [4] = '{3, 4, 5, 6};
   logic clock = 1'b0;
   logic rst_n, on_request, sleep_in, button_n, button_is_reset;
   logic irq_req, ninth_req, ninth_en, irq_o, irq_oe, por_o, por_oe;
   logic long_press_warn;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, resource_en;
   logic reg_we, reg_re;
   logic [2:0] device_state;
   int error_cnt = 0;
   int total_checks = 0;
   int cycles = 0;

   // 100 MHz clock
   always #5 clock = ~clock;

   host_port_model host_u (.clock(clock), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata));

   // short counts keep the run small
   device_state_control #(.SLOT0_CYC(3), .SLOT1_CYC(4), .SLOT2_CYC(5),
      .SLOT3_CYC(6), .LP_WARN_CYC(20), .LP_OFF_CYC(30)) dut_u (
      .CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re),
      .REG_RDATA(reg_rdata), .ON_REQUEST(on_request),
      .SLEEP_IN(sleep_in), .POWER_BUTTON_IN_N(button_n),
      .BUTTON_IS_RESET(button_is_reset), .IRQ_REQ(irq_req),
      .NINTH_REG_REQ(ninth_req), .RESOURCE_EN(resource_en),
      .NINTH_REG_EN(ninth_en), .IRQ_PAD_O(irq_o), .IRQ_PAD_OE(irq_oe),
      .POWER_ON_RESET_OUT_N_O(por_o), .POWER_ON_RESET_OUT_N_OE(por_oe),
      .DEVICE_STATE(device_state), .LONG_PRESS_WARN(long_press_warn));

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // hang guard: the whole run needs under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host_u.rd(a, d);
      chk(d, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // bounded wait for a state; running out shows as a mismatch
   task automatic wait_st(input logic [2:0] s);
      int n;
      n = 0;
      while (device_state !== s && n < 200) begin
         idle(1);
         n++;
      end
      chk({5'h0, device_state}, {5'h0, s});
   endtask

   // power up, timing the gap between the first two enables
   task automatic power_up(input int k);
      int n;
      n = 0;
      on_request = 1'b1;
      while (resource_en[0] !== 1'b1 && n < 100) begin
         idle(1);
         n++;
      end
      n = 0;
      while (resource_en[1] !== 1'b1 && n < 100) begin
         idle(1);
         n++;
      end
      chk(8'(n), 8'(slot_cyc[k]));
      wait_st(3'h3);
      on_request = 1'b0;
   endtask

   initial begin
      logic [7:0] cv;
      logic [7:0] irq_cfg [4];
      logic [7:0] irq_exp [4];
      int n;
      irq_cfg = '{8'h41, 8'h40, 8'h00, 8'h00};
      irq_exp = '{8'h03, 8'h01, 8'h01, 8'h00};
      rst_n = 1'b0;
      on_request = 1'b0;
      sleep_in = 1'b0;
      button_n = 1'b1;
      button_is_reset = 1'b0;
      irq_req = 1'b0;
      ninth_req = 1'b0;
      repeat (16) @(posedge clock);
      #1;
      rst_n = 1'b1;
      idle(1);
      // reset values, unmapped and read-only places
      rchk(ADDR_CTRL, 8'h40);
      rchk(ADDR_CTRL2, 8'h70);
      rchk(8'h26, 8'h00);
      host_u.wr(ADDR_CTRL, 8'h78);
      rchk(ADDR_CTRL, 8'h48);
      chk({6'h0, por_o, por_oe}, 8'h01);
      $display("registers test done");
      // every slot code, both shutdown orders, reload on and off
      for (int k = 0; k < 4; k++) begin
         cv = {k[1], 1'(k != 3), 2'b00, k[0], 3'b100};
         host_u.wr(ADDR_CTRL, cv);
         host_u.wr(ADDR_CTRL2, 8'(k << 4));
         power_up(k);
         idle(10);
         chk({5'h0, device_state}, 8'h03);
         chk({6'h0, por_o & por_oe, por_oe}, k[0] ? 8'h03 : 8'h00);
         host_u.wr(ADDR_CTRL, cv | 8'h01);
         n = 0;
         while (resource_en === 8'hff && n < 100) begin
            idle(1);
            n++;
         end
         chk(resource_en, k[1] ? 8'h7f : 8'h00);
         wait_st(3'h0);
         idle(2);
         rchk(ADDR_CTRL, (k != 3) ? 8'h40 : 8'h88);
         rchk(ADDR_CTRL2, (k != 3) ? 8'h70 : 8'h30);
      end
      $display("sequencing test done");
      // sleep pin enable and polarity, wake by clearing sleep-allow
      host_u.wr(ADDR_CTRL2, 8'h80);
      host_u.wr(ADDR_CTRL, 8'h06);
      power_up(0);
      idle(5);
      chk({5'h0, device_state}, 8'h03);
      sleep_in = 1'b1;
      wait_st(3'h2);
      host_u.wr(ADDR_CTRL2, 8'h88);
      wait_st(3'h3);
      sleep_in = 1'b0;
      wait_st(3'h2);
      host_u.wr(ADDR_CTRL, 8'h04);
      wait_st(3'h3);
      host_u.wr(ADDR_CTRL2, 8'h00);
      host_u.wr(ADDR_CTRL, 8'h06);
      wait_st(3'h2);
      host_u.wr(ADDR_CTRL, 8'h04);
      wait_st(3'h3);
      ninth_req = 1'b1;
      idle(3);
      chk({7'h0, ninth_en}, 8'h01);
      $display("sleep test done");
      // interrupt pad drive mode and polarity
      for (int j = 0; j < 4; j++) begin
         irq_req = (j != 3);
         host_u.wr(ADDR_CTRL2, irq_cfg[j]);
         idle(3);
         chk({6'h0, irq_o & irq_oe, irq_oe}, irq_exp[j]);
      end
      $display("interrupt pad test done");
      // long press: ignored as reset input, then warn and off
      button_is_reset = 1'b1;
      host_u.wr(ADDR_CTRL2, 8'h04);
      button_n = 1'b0;
      idle(40);
      chk({5'h0, device_state}, 8'h03);
      button_n = 1'b1;
      button_is_reset = 1'b0;
      idle(2);
      button_n = 1'b0;
      idle(15);
      chk({7'h0, long_press_warn}, 8'h00);
      idle(10);
      chk({7'h0, long_press_warn}, 8'h01);
      wait_st(3'h0);
      button_n = 1'b1;
      // reset variant reloads both registers on the way off
      host_u.wr(ADDR_CTRL, 8'h04);
      host_u.wr(ADDR_CTRL2, 8'h06);
      power_up(0);
      button_n = 1'b0;
      wait_st(3'h0);
      button_n = 1'b1;
      idle(2);
      rchk(ADDR_CTRL2, 8'h70);
      rchk(ADDR_CTRL, 8'h40);
      chk({7'h0, ninth_en}, 8'h00);
      $display("long press test done");
      // second power-on reset in mid-run restores programmed defaults
      host_u.wr(ADDR_CTRL2, 8'h00);
      rst_n = 1'b0;
      idle(3);
      rst_n = 1'b1;
      idle(1);
      rchk(ADDR_CTRL2, 8'h70);
      rchk(ADDR_CTRL, 8'h40);
      $display("reset test done");
      finish_test();
   end
endmodule // tb
